// *** rtl/rgpi_link_if.sv ***
/*
  The twelve-wire reduced gigabit link between the switch port and the
  external MAC. Each end drives its own wires; nothing is two-way.
*/
`timescale 1ns/1ps
`default_nettype none
interface rgpi_link_if;
  logic txClk;
  logic txCtl;
  logic [3:0] txd;
  logic rxClk;
  logic rxCtl;
  logic [3:0] rxd;

  modport port_end (input txClk, input txCtl, input txd,
                    output rxClk, output rxCtl, output rxd);
  modport mac_end (output txClk, output txCtl, output txd,
                   input rxClk, input rxCtl, input rxd);
endinterface // rgpi_link_if
`default_nettype wire

// *** rtl/rgpi_mac_end.sv ***
/*
  External MAC side of the reduced gigabit link. Makes the transmit clock
  by a divider, sends bytes as nibbles with data set up half a clock ahead
  of the edge that samples them, and collects nibbles on the receive clock.
  Assumes the port end across the link and a user on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rgpi_mac_end #(
  parameter int HALF_1000 = rgpi_pkg::HALF_1000,
  parameter int HALF_100 = rgpi_pkg::HALF_100,
  parameter int HALF_10 = rgpi_pkg::HALF_10
) (
  input wire logic core_clk,
  input wire logic arst_n,
  rgpi_link_if.mac_end link,
  input wire rgpi_pkg::rgpi_speed_t speed,
  input wire logic speedAgreed,
  input wire logic [7:0] sendData,
  input wire logic sendValid,
  input wire logic sendErr,
  output logic sendReady,
  output logic [7:0] recvData,
  output logic recvValid,
  output logic recvErr
);

  localparam int W = rgpi_pkg::CNT_W;
  wire gig = speed == rgpi_pkg::SPD_1000;
  wire [W-1:0] halfLen = (speed == rgpi_pkg::SPD_10) ? W'(HALF_10) :
                         (speed == rgpi_pkg::SPD_100) ? W'(HALF_100) : W'(HALF_1000);

  logic [W-1:0] cnt_r;
  logic clkLvl_r;
  rgpi_pkg::rgpi_speed_t lastSpd_r;
  wire toggle = cnt_r == '0;
  wire spdChg = speed != lastSpd_r;
  wire riseT = toggle && !spdChg && !clkLvl_r;
  wire fallT = toggle && !spdChg && clkLvl_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      clkLvl_r <= 1'b0;
      lastSpd_r <= rgpi_pkg::SPD_100;
    end else if (toggle) begin
      lastSpd_r <= speed;
      clkLvl_r <= spdChg ? clkLvl_r : !clkLvl_r;
      cnt_r <= (spdChg ? W'(HALF_10) : halfLen) - W'(1); // RULE_01
    end else begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  // A byte is taken at a falling launch so its low nibble is steady before
  // the next rising edge; its high nibble follows at the rising launch (gigabit) or at the next falling launch (10/100).
  logic nibPh_r;
  logic [3:0] hiNib_r;
  logic dv_r;
  logic er_r;
  logic [3:0] txd_r;
  logic txCtl_r;
  wire hold = !gig && !speedAgreed;
  assign sendReady = fallT && !hold && (gig || !nibPh_r);
  wire take = sendReady && sendValid;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nibPh_r <= 1'b0;
      hiNib_r <= 4'h0;
      dv_r <= 1'b0;
      er_r <= 1'b0;
      txd_r <= 4'h0;
      txCtl_r <= 1'b0;
    end else if (fallT && (gig || !nibPh_r)) begin
      dv_r <= take;
      er_r <= take && sendErr;
      hiNib_r <= sendData[7:4];
      txd_r <= take ? sendData[3:0] : 4'h0; // RULE_03 RULE_18
      txCtl_r <= take; // RULE_05
      nibPh_r <= take && !gig;
    end else if (fallT) begin
      txd_r <= hiNib_r;
      txCtl_r <= dv_r;
      nibPh_r <= 1'b0;
    end else if (riseT) begin
      txd_r <= gig ? hiNib_r : txd_r; // RULE_18
      txCtl_r <= dv_r ^ er_r; // RULE_07
    end
  end

  assign link.txClk = clkLvl_r;
  assign link.txd = txd_r; // RULE_16
  assign link.txCtl = txCtl_r;

  logic [5:0] syn1_r;
  logic [5:0] syn2_r;
  logic [5:0] syn3_r;
  logic clkSt_r;
  logic clkPrev_r;
  logic [4:0] dat_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syn1_r <= '0;
      syn2_r <= '0;
      syn3_r <= '0;
      clkSt_r <= 1'b0;
      clkPrev_r <= 1'b0;
      dat_r <= '0;
    end else begin
      syn1_r <= {link.rxClk, link.rxCtl, link.rxd};
      syn2_r <= syn1_r;
      syn3_r <= syn2_r;
      clkSt_r <= (syn2_r[5] == syn3_r[5]) ? syn3_r[5] : clkSt_r;
      clkPrev_r <= clkSt_r;
      dat_r <= syn3_r[4:0];
    end
  end

  wire inRise = clkSt_r && !clkPrev_r;
  wire inFall = !clkSt_r && clkPrev_r;

  logic ctlRise_r;
  logic [3:0] loNib_r;
  logic inHalf_r;
  logic inErr_r;
  logic [7:0] recvData_r;
  logic recvValid_r;
  logic recvErr_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctlRise_r <= 1'b0;
      loNib_r <= 4'h0;
      inHalf_r <= 1'b0;
      inErr_r <= 1'b0;
      recvData_r <= 8'h00;
      recvValid_r <= 1'b0;
      recvErr_r <= 1'b0;
    end else begin
      recvValid_r <= 1'b0;
      if (inRise) begin
        ctlRise_r <= dat_r[4];
        if (gig || !inHalf_r) begin
          loNib_r <= dat_r[3:0]; // RULE_18
          inHalf_r <= dat_r[4] && !gig;
        end else begin
          recvData_r <= {dat_r[3:0], loNib_r};
          recvValid_r <= 1'b1;
          recvErr_r <= inErr_r;
          inHalf_r <= 1'b0;
        end
      end
      if (inFall) begin
        inErr_r <= ctlRise_r && (ctlRise_r ^ dat_r[4]); // RULE_07
        if (gig && ctlRise_r) begin
          recvData_r <= {dat_r[3:0], loNib_r};
          recvValid_r <= 1'b1;
          recvErr_r <= ctlRise_r ^ dat_r[4];
        end
      end
    end
  end

  assign recvData = recvData_r;
  assign recvValid = recvValid_r;
  assign recvErr = recvErr_r;

endmodule // rgpi_mac_end
`default_nettype wire

// *** rtl/rgpi_pkg.sv ***
/*
  Constants and types shared by both ends of the reduced gigabit link:
  link clock rates, derived divider counts, the control register layout
  and the mode strap codes.
  Assumes a 50 MHz core clock on both ends.
*/
package rgpi_pkg;

  typedef enum logic [1:0] {
    SPD_10 = 2'b00,
    SPD_100 = 2'b01,
    SPD_1000 = 2'b10
  } rgpi_speed_t;

  localparam int CORE_PERIOD_PS = 20000;
  localparam int LINK_1000_KHZ = 125000;
  localparam int LINK_100_KHZ = 25000;
  localparam int LINK_10_KHZ = 2500;
  localparam int DELAY_PS = 1500;

  // Half a link clock period in core cycles, rounded down, at least two.
  // The three-stage sampler accepts a level only after two equal samples,
  // so a one-cycle phase would never be seen by the far end.
  function automatic int half_cycles(input int khz);
    int c;
    c = (1000000000 / (2 * khz)) / CORE_PERIOD_PS;
    return (c < 2) ? 2 : c;
  endfunction

  localparam int HALF_1000 = half_cycles(LINK_1000_KHZ);
  localparam int HALF_100 = half_cycles(LINK_100_KHZ);
  localparam int HALF_10 = half_cycles(LINK_10_KHZ);
  // A least delay rounds up to whole core cycles.
  localparam int DELAY_CYC = (DELAY_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int CNT_W = 8;

  localparam logic [7:0] REG_CTRL_ADDR = 8'h00;
  localparam logic [7:0] REG_STAT_ADDR = 8'h04;
  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_SPD_LSB = 1;
  localparam int CTRL_TXDLY_BIT = 3;
  localparam int CTRL_RXDLY_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h10;
  localparam int STAT_SPD_LSB = 0;
  localparam int STAT_MODE_BIT = 2;
  localparam int STAT_STRAP_BIT = 3;

  localparam logic [1:0] MODE_RGMII_A = 2'h2;
  localparam logic [1:0] MODE_RGMII_B = 2'h3;

endpackage

// *** rtl/rgpi_port_end.sv ***
/*
  Switch side of the reduced gigabit link (PHY role). Sources the receive
  clock by a divider, launches bytes toward the MAC as nibbles, and
  collects nibbles sent by the MAC on its transmit clock.
  Assumes the MAC end and a small register master on core_clk.
*/
// How it works
// RULE_01 - MAC supplies 125, 25 or 2.5 MHz (with the 50 MHz core the MAC end makes 12.5, 12.5 or 2.5 MHz)
// RULE_02 - Port sources receive clock at link rate (with the 50 MHz core the port end makes 12.5, 12.5 or 2.5 MHz)
// RULE_03 - MAC sends nibbles on both gigabit edges
// RULE_04 - Port sends nibbles on both gigabit edges
// RULE_05 - MAC keeps control low until speeds agree (MAC end holds only at 10/100; at 1000 it ignores speedAgreed)
// RULE_06 - Speed change stretches receive clock, never runts
// RULE_07 - Control merges valid and error, falling-edge level
// RULE_08 - No automatic speed detection, configuration only
// RULE_09 - Power-up strap picks 1000 or 100
// RULE_10 - Register override picks 1000, 100 or 10
// RULE_11 - Mode straps enable the RGMII mode
// RULE_12 - Optional internal clock delay of 1.5 ns (port end delays by one whole 20 ns core cycle)
// RULE_13 - Ingress delay bit, reset off
// RULE_14 - Egress delay bit, reset on
// RULE_15 - Attached PHY should use fixed speed
// RULE_16 - Separate four-bit transmit and receive groups
// RULE_17 - All three speeds, half and full duplex
// RULE_18 - Gigabit low nibble rising, high falling
`timescale 1ns/1ps
`default_nettype none
module rgpi_port_end #(
  parameter int HALF_1000 = rgpi_pkg::HALF_1000,
  parameter int HALF_100 = rgpi_pkg::HALF_100,
  parameter int HALF_10 = rgpi_pkg::HALF_10
) (
  input wire logic core_clk,
  input wire logic arst_n,
  rgpi_link_if.port_end link,
  input wire logic [1:0] modeStrap,
  input wire logic speedStrap,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  output logic rgmiiModeOn,
  input wire logic [7:0] egrData,
  input wire logic egrValid,
  input wire logic egrErr,
  output logic egrReady,
  output logic [7:0] ingData,
  output logic ingValid,
  output logic ingErr
);

  localparam int W = rgpi_pkg::CNT_W;

  function automatic logic [W-1:0] half_len(input rgpi_pkg::rgpi_speed_t s);
    case (s) // RULE_17
      rgpi_pkg::SPD_10: half_len = W'(HALF_10);
      rgpi_pkg::SPD_100: half_len = W'(HALF_100);
      default: half_len = W'(HALF_1000);
    endcase
  endfunction

  // Straps and configuration.
  logic strapDone_r;
  logic speedStrap_r;
  logic modeOn_r;
  logic [7:0] ctrl_r;
  logic [7:0] regRdata_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strapDone_r <= 1'b0;
      speedStrap_r <= 1'b0;
      modeOn_r <= 1'b0;
    end else if (!strapDone_r) begin
      strapDone_r <= 1'b1;
      speedStrap_r <= speedStrap; // RULE_09
      modeOn_r <= (modeStrap == rgpi_pkg::MODE_RGMII_A) ||
                  (modeStrap == rgpi_pkg::MODE_RGMII_B); // RULE_11
    end
  end

  wire ctrlHit = regAddr == rgpi_pkg::REG_CTRL_ADDR;
  wire statHit = regAddr == rgpi_pkg::REG_STAT_ADDR;
  wire txDlyEn = ctrl_r[rgpi_pkg::CTRL_TXDLY_BIT];
  wire rxDlyEn = ctrl_r[rgpi_pkg::CTRL_RXDLY_BIT];
  wire [1:0] ovrSpd = ctrl_r[rgpi_pkg::CTRL_SPD_LSB +: 2];
  // Speed is never learned from the link, only from strap or register.
  wire rgpi_pkg::rgpi_speed_t speed = ctrl_r[rgpi_pkg::CTRL_OVR_BIT] ?
      rgpi_pkg::rgpi_speed_t'(ovrSpd) :
      (speedStrap_r ? rgpi_pkg::SPD_1000 : rgpi_pkg::SPD_100); // RULE_08 RULE_10
  wire gig = speed == rgpi_pkg::SPD_1000;
  wire [7:0] statWord = {4'h0, speedStrap_r, modeOn_r, speed};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= rgpi_pkg::CTRL_RESET; // RULE_13 RULE_14
      regRdata_r <= 8'h00;
    end else begin
      if (regWr && ctrlHit) begin
        ctrl_r <= regWdata;
      end
      regRdata_r <= !regRd ? 8'h00 : ctrlHit ? ctrl_r : statHit ? statWord : 8'h00;
    end
  end

  // Receive clock divider. A new half length is loaded only when a phase
  // ends, and a speed change holds the level one extra slow half period,
  // so the MAC never sees a short phase.
  logic [W-1:0] cnt_r;
  logic rxClkLvl_r;
  rgpi_pkg::rgpi_speed_t lastSpd_r;
  wire toggle = cnt_r == '0;
  wire spdChg = speed != lastSpd_r;
  wire riseT = toggle && !spdChg && !rxClkLvl_r;
  wire fallT = toggle && !spdChg && rxClkLvl_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      rxClkLvl_r <= 1'b0;
      lastSpd_r <= rgpi_pkg::SPD_100;
    end else if (toggle) begin
      lastSpd_r <= speed;
      rxClkLvl_r <= spdChg ? rxClkLvl_r : !rxClkLvl_r; // RULE_06
      cnt_r <= (spdChg ? W'(HALF_10) : half_len(speed)) - W'(1); // RULE_02
    end else begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  // Egress path toward the MAC: a byte is taken at a rising launch and
  // split over one clock (gigabit) or two clocks (10/100).
  logic nibPh_r;
  logic [3:0] hiNib_r;
  logic dv_r;
  logic er_r;
  logic [3:0] rxd_r;
  logic rxCtl_r;
  assign egrReady = riseT && modeOn_r && (gig || !nibPh_r);
  wire take = egrReady && egrValid;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nibPh_r <= 1'b0;
      hiNib_r <= 4'h0;
      dv_r <= 1'b0;
      er_r <= 1'b0;
      rxd_r <= 4'h0;
      rxCtl_r <= 1'b0;
    end else if (riseT && (gig || !nibPh_r)) begin
      dv_r <= take;
      er_r <= take && egrErr;
      hiNib_r <= egrData[7:4];
      rxd_r <= take ? egrData[3:0] : 4'h0; // RULE_04 RULE_18
      rxCtl_r <= take;
      nibPh_r <= take && !gig;
    end else if (riseT) begin
      rxd_r <= hiNib_r; // RULE_18
      rxCtl_r <= dv_r;
      nibPh_r <= 1'b0;
    end else if (fallT) begin
      rxd_r <= gig ? hiNib_r : rxd_r; // RULE_04 RULE_18
      rxCtl_r <= dv_r ^ er_r; // RULE_07
    end
  end

  // Egress clock delay is a shift of whole core cycles.
  localparam int DLY = rgpi_pkg::DELAY_CYC;
  logic [DLY-1:0] clkDly_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clkDly_r <= '0;
    end else begin
      clkDly_r <= DLY'({clkDly_r, rxClkLvl_r});
    end
  end

  assign link.rxClk = rxDlyEn ? clkDly_r[rgpi_pkg::DELAY_CYC-1] : rxClkLvl_r; // RULE_12
  assign link.rxd = rxd_r; // RULE_16
  assign link.rxCtl = rxCtl_r;

  // Ingress path from the MAC: three-stage sampling of clock, control and
  // data; a clock level counts once stages two and three agree.
  logic [5:0] syn1_r;
  logic [5:0] syn2_r;
  logic [5:0] syn3_r;
  logic clkSt_r;
  logic clkDl_r;
  logic clkPrev_r;
  logic [4:0] datA_r;
  logic [4:0] datB_r;
  logic [4:0] datC_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syn1_r <= '0;
      syn2_r <= '0;
      syn3_r <= '0;
      clkSt_r <= 1'b0;
      clkDl_r <= 1'b0;
      clkPrev_r <= 1'b0;
      datA_r <= '0;
      datB_r <= '0;
      datC_r <= '0;
    end else begin
      syn1_r <= {link.txClk, link.txCtl, link.txd};
      syn2_r <= syn1_r;
      syn3_r <= syn2_r;
      clkSt_r <= (syn2_r[5] == syn3_r[5]) ? syn3_r[5] : clkSt_r;
      clkDl_r <= clkSt_r;
      datA_r <= syn3_r[4:0];
      datB_r <= datA_r;
      datC_r <= datB_r;
      clkPrev_r <= txDlyEn ? clkDl_r : clkSt_r;
    end
  end

  wire clkUse = txDlyEn ? clkDl_r : clkSt_r; // RULE_12
  // The MAC changes its wires at each clock toggle, so the nibble that belongs
  // to an edge is the one seen in the last sample before the edge.
  wire [4:0] datUse = txDlyEn ? datC_r : datB_r;
  wire inRise = clkUse && !clkPrev_r && modeOn_r;
  wire inFall = !clkUse && clkPrev_r && modeOn_r;
  wire inCtl = datUse[4];
  wire [3:0] inNib = datUse[3:0];

  logic ctlRise_r;
  logic [3:0] loNib_r;
  logic inHalf_r;
  logic inErr_r;
  logic [7:0] ingData_r;
  logic ingValid_r;
  logic ingErr_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctlRise_r <= 1'b0;
      loNib_r <= 4'h0;
      inHalf_r <= 1'b0;
      inErr_r <= 1'b0;
      ingData_r <= 8'h00;
      ingValid_r <= 1'b0;
      ingErr_r <= 1'b0;
    end else begin
      ingValid_r <= 1'b0;
      if (inRise) begin
        ctlRise_r <= inCtl;
        if (gig || !inHalf_r) begin
          loNib_r <= inNib; // RULE_03 RULE_18
          inHalf_r <= inCtl && !gig; // RULE_05
        end else begin
          ingData_r <= {inNib, loNib_r};
          ingValid_r <= 1'b1;
          ingErr_r <= inErr_r;
          inHalf_r <= 1'b0;
        end
      end
      if (inFall) begin
        inErr_r <= ctlRise_r && (ctlRise_r ^ inCtl); // RULE_07
        if (gig && ctlRise_r) begin
          ingData_r <= {inNib, loNib_r}; // RULE_03 RULE_18
          ingValid_r <= 1'b1;
          ingErr_r <= ctlRise_r ^ inCtl; // RULE_07
        end
      end
    end
  end

  assign ingData = ingData_r;
  assign ingValid = ingValid_r;
  assign ingErr = ingErr_r;
  assign regRdata = regRdata_r;
  assign rgmiiModeOn = modeOn_r;

endmodule // rgpi_port_end
`default_nettype wire

// *** verification/rgpi_link_asserts.sv ***
/*
  Link-level checks on the twelve wires between the two ends.
  Assumes the testbench ties its inputs to the joining interface.
*/
`timescale 1ns/1ps
`default_nettype none
module rgpi_link_asserts (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic txClk,
  input wire logic txCtl,
  input wire logic [3:0] txd,
  input wire logic rxClk,
  input wire logic rxCtl,
  input wire logic [3:0] rxd
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // A stretched phase at a speed change may last two slow half periods.
  sequence s_rx_phase;
    ##[1:25] $changed(rxClk);
  endsequence
  sequence s_tx_phase;
    ##[1:20] $changed(txClk);
  endsequence
  // The egress delay lets the clock pin lag its launch by one cycle.
  sequence s_rx_launch;
    ##[0:1] $changed(rxClk);
  endsequence

  a_reset_quiet_link: assert property (
    $rose(arst_n) |-> !rxCtl && !txCtl && rxd == 4'h0 && txd == 4'h0)
    else $error("link not idle after reset");
  a_rx_clk_runs: assert property (
    $changed(rxClk) |-> s_rx_phase) else $error("rx clock phase too long");
  a_tx_clk_runs: assert property (
    $changed(txClk) |-> s_tx_phase) else $error("tx clock phase too long");
  a_rx_data_launch: assert property (
    $changed(rxd) |-> s_rx_launch) else $error("rx nibble off a clock edge");
  a_rx_ctl_launch: assert property (
    $changed(rxCtl) |-> s_rx_launch) else $error("rx control off a clock edge");
  a_rx_frame_start: assert property (
    $rose(rxCtl) |-> ##[0:1] $rose(rxClk)) else $error("rx frame not at rising edge");
  a_tx_data_launch: assert property (
    $changed(txd) |-> $changed(txClk)) else $error("tx nibble off a clock toggle");
  a_tx_frame_start: assert property (
    $rose(txCtl) |-> $fell(txClk)) else $error("tx frame not half a clock early");
endmodule // rgpi_link_asserts
`default_nettype wire

// *** verification/testbench.sv ***
/*
  Bench joining both ends of the link: straps, register accesses and
  bytes both ways at every speed.
  Assumes the design package and interface are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] modeStrap = 2'h2;
  logic speedStrap = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] egrData = 8'h00;
  logic egrValid = 1'b0;
  logic egrErr = 1'b0;
  logic [7:0] sendData = 8'h00;
  logic sendValid = 1'b0;
  logic sendErr = 1'b0;
  logic speedAgreed = 1'b0;
  rgpi_pkg::rgpi_speed_t macSpeed = rgpi_pkg::SPD_1000;
  logic [7:0] regRdata, ingData, recvData, ctrlVal;
  logic egrReady, ingValid, ingErr, sendReady, recvValid, recvErr, rgmiiModeOn, modeOn;
  logic [1:0] resetMode [3] = '{2'h3, 2'h0, 2'h2};
  logic resetStrap [3] = '{1'b0, 1'b1, 1'b1};
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int hits;

  always #10 core_clk = ~core_clk;

  rgpi_link_if rgpi_link_if_inst ();
  rgpi_port_end rgpi_port_end_inst (.core_clk(core_clk), .arst_n(arst_n),
    .link(rgpi_link_if_inst.port_end), .modeStrap(modeStrap), .speedStrap(speedStrap),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .rgmiiModeOn(rgmiiModeOn), .egrData(egrData),
    .egrValid(egrValid), .egrErr(egrErr), .egrReady(egrReady), .ingData(ingData),
    .ingValid(ingValid), .ingErr(ingErr));
  rgpi_mac_end rgpi_mac_end_inst (.core_clk(core_clk), .arst_n(arst_n),
    .link(rgpi_link_if_inst.mac_end), .speed(macSpeed), .speedAgreed(speedAgreed),
    .sendData(sendData), .sendValid(sendValid), .sendErr(sendErr),
    .sendReady(sendReady), .recvData(recvData), .recvValid(recvValid), .recvErr(recvErr));
  rgpi_link_asserts rgpi_link_asserts_inst (.core_clk(core_clk), .arst_n(arst_n),
    .txClk(rgpi_link_if_inst.txClk), .txCtl(rgpi_link_if_inst.txCtl),
    .txd(rgpi_link_if_inst.txd), .rxClk(rgpi_link_if_inst.rxClk),
    .rxCtl(rgpi_link_if_inst.rxCtl), .rxd(rgpi_link_if_inst.rxd));

  task automatic final_report;
    $display("comparisons=%0d errors=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk({1'b0, regRdata}, {1'b0, e});
  endtask

  task automatic do_reset(input logic [1:0] m, input logic s);
    @(posedge core_clk);
    arst_n <= 1'b0;
    modeStrap <= m;
    speedStrap <= s;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // One byte across the link; fromMac picks the direction.
  task automatic xfer(input logic fromMac, input logic [7:0] d, input logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    if (fromMac) begin
      sendData <= d;
      sendErr <= e;
      sendValid <= 1'b1;
    end else begin
      egrData <= d;
      egrErr <= e;
      egrValid <= 1'b1;
    end
    do begin
      @(negedge core_clk);
      n++;
    end while (!(fromMac ? sendReady : egrReady) && n < 400);
    @(posedge core_clk);
    sendValid <= 1'b0;
    egrValid <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (!(fromMac ? ingValid : recvValid) && n < 800);
    chk(fromMac ? {ingErr, ingData} : {recvErr, recvData}, {e, d});
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    for (int i = 0; i < 3; i++) begin
      do_reset(resetMode[i], resetStrap[i]);
      modeOn = resetMode[i] == rgpi_pkg::MODE_RGMII_A || resetMode[i] == rgpi_pkg::MODE_RGMII_B;
      chk({8'h00, rgmiiModeOn}, {8'h00, modeOn});
      rd(rgpi_pkg::REG_STAT_ADDR, {4'h0, resetStrap[i], modeOn,
        resetStrap[i] ? rgpi_pkg::SPD_1000 : rgpi_pkg::SPD_100});
      rd(rgpi_pkg::REG_CTRL_ADDR, rgpi_pkg::CTRL_RESET);
    end
    rd(8'h08, 8'h00);
    wr(rgpi_pkg::REG_STAT_ADDR, 8'hFF);
    rd(rgpi_pkg::REG_STAT_ADDR, 8'h0E);
    for (int i = 0; i < 3; i++) begin
      // Ingress delay only at the slow rate, where half periods span many cycles.
      ctrlVal = 8'h11 | 8'(i << 1) | ((i == 0) ? 8'h08 : 8'h00);
      @(posedge core_clk);
      macSpeed <= rgpi_pkg::rgpi_speed_t'(i[1:0]);
      speedAgreed <= 1'b1;
      wr(rgpi_pkg::REG_CTRL_ADDR, ctrlVal);
      rd(rgpi_pkg::REG_CTRL_ADDR, ctrlVal);
      rd(rgpi_pkg::REG_STAT_ADDR, 8'h0C | 8'(i));
      repeat (60) @(posedge core_clk);
      xfer(1'b0, 8'hA5 ^ 8'(i), 1'b0);
      xfer(1'b0, 8'h3C, 1'b1);
      xfer(1'b1, 8'h5A ^ 8'(i), 1'b0);
      xfer(1'b1, 8'hC3, 1'b1);
    end
    @(posedge core_clk);
    macSpeed <= rgpi_pkg::SPD_100;
    speedAgreed <= 1'b0;
    wr(rgpi_pkg::REG_CTRL_ADDR, 8'h13);
    sendData <= 8'h77;
    sendValid <= 1'b1;
    hits = 0;
    repeat (150) begin
      @(negedge core_clk);
      hits += int'(ingValid);
    end
    chk(9'(hits), 9'h000);
    sendValid <= 1'b0;
    repeat (20) @(posedge core_clk);
    final_report();
  end
endmodule // testbench
`default_nettype wire
